/* File: src/tlic_pin_sync.sv */
// three-stage pin synchroniser with edge-selected event pulse
`timescale 1ns/10ps
`default_nettype none

module tlic_pin_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // pin and edge choice
  input  wire logic pin_in,
  input  wire logic edge_rise,
  // agreed level and one-cycle event
  output var  logic level,
  output var  logic edge_event
);

  logic s1;
  logic s2;
  logic s3;
  logic [2:0] fill;

  // the level takes the pin's idle state silently until the chain has filled,
  // so a pin resting high after reset gives no false rising edge
  always_ff @(posedge clock) begin
    if (rst) begin
      fill <= 3'h0;
    end else if (fill != 3'h4) begin
      fill <= fill + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge clock) begin
    if (rst) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      edge_event <= 1'b0;
    end else begin
      edge_event <= (fill == 3'h4) && (s2 == s3) && (s3 != level)
                    && (s3 == edge_rise);
    end
  end

endmodule

`default_nettype wire

/* File: src/tlic_pkg.sv */
// shared constants and types of the two-level interrupt controller
package tlic_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // program addresses
  localparam int unsigned ADDR_W = 21;
  localparam logic [20:0] HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] LOW_VECTOR  = 21'h000018;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLOCK_HZ        = 20_000_000;
  localparam int unsigned CLOCK_PERIOD_NS = 50;
  // one instruction cycle takes four oscillator clocks
  localparam int unsigned CLKS_PER_INSTR  = 4;
  localparam int unsigned INSTR_PERIOD_NS = 200;
  localparam int unsigned INSTR_CLKS      = INSTR_PERIOD_NS / CLOCK_PERIOD_NS;
  // instruction cycles from capture of a request to the vector
  localparam int unsigned LATENCY_INSTR   = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic GEN_RESET    = 1'b0;
  localparam logic ACTIVE_RESET = 1'b0;
  localparam logic FLAG_RESET   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [1:0] {
    TLIC_IDLE = 2'b01,
    TLIC_WAIT = 2'b10
  } tlic_state_e;

endpackage

/* File: src/tlic_top.sv */
// two-level vectored interrupt controller
//
// Notes on behaviour
// - high-level requests vector to 0008h, low-level requests to 0018h
// - a pending high-level request preempts a running low-level handler
// - every source has a flag, an enable and a level-select bit
// - two-level operation only while the priority-levels enable is set
// - with levels on, bit 7 enables high sources, bit 6 low sources
// - flag, enable and matching global enable all set: vector by level bit
// - a source whose own enable is clear never causes a vector
// - levels off (reset default) is compatibility mode, level bits ignored
// - compatibility: bit 6 enables peripheral group, bit 7 enables everything
// - compatibility: every accepted interrupt goes to 0008h
// - accepting clears the global enable that admitted the request
// - no low-level interrupt while a high-level handler runs
// - accepting pushes the return address and loads the vector into the pc
// - return-from-handler leaves the handler and sets its global enable again
// - pin events reach the vector three to four instruction cycles after their flag sets
// - flags set on their event regardless of any enable
// - each external pin edge select: 1 rising, 0 falling
// - port-change flag keeps setting until a port read ends the mismatch
`timescale 1ns/10ps
`default_nettype none

module tlic_top #(
  parameter int unsigned N_EXT  = 4,
  parameter int unsigned N_PORT = 4,
  parameter int unsigned N_PER  = 8,
  parameter int unsigned N_SRC  = N_EXT + 1 + N_PER
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // mode and global enable writes from software
  input  wire logic                      priority_levels_enable,
  input  wire logic                      hi_gen_set,
  input  wire logic                      hi_gen_clr,
  input  wire logic                      lo_gen_set,
  input  wire logic                      lo_gen_clr,
  // per-source controls from software
  input  wire logic [N_SRC-1:0]          src_enable,
  input  wire logic [N_SRC-1:0]          src_priority,
  input  wire logic [N_SRC-1:0]          flag_clear,
  input  wire logic [N_EXT-1:0]          ext_pin_edge_select,
  // event sources
  input  wire logic [N_EXT-1:0]          ext_pin,
  input  wire logic [N_PORT-1:0]         port_pin,
  input  wire logic                      port_read,
  input  wire logic [N_PER-1:0]          periph_event,
  // processor core
  input  wire logic                      return_from_handler_instr,
  output var  logic                      stack_push,
  output var  logic                      pc_load,
  output var  logic [tlic_pkg::ADDR_W-1:0] pc_vector,
  // status
  output var  logic                      high_level_global_enable,
  output var  logic                      low_level_global_enable,
  output var  logic                      high_handler_active,
  output var  logic                      low_handler_active,
  output var  logic [N_SRC-1:0]          src_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (N_EXT < 1 || N_EXT > 8) begin : g_bad_ext
    $error("N_EXT must lie in 1..8");
  end
  if (N_PORT < 1 || N_PORT > 8) begin : g_bad_port
    $error("N_PORT must lie in 1..8");
  end
  if (N_PER < 1) begin : g_bad_per
    $error("N_PER must be at least 1");
  end
  if (N_SRC != N_EXT + 1 + N_PER) begin : g_bad_src
    $error("N_SRC must equal N_EXT + 1 + N_PER");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int unsigned DIV_W = $clog2(tlic_pkg::INSTR_CLKS);
  localparam int unsigned LAT_W = $clog2(tlic_pkg::LATENCY_INSTR + 1);
  localparam int unsigned PORT_IDX = N_EXT;

  // sources above the port-change slot form the peripheral group
  localparam logic [N_SRC-1:0] PERIPH_MASK = {{N_PER{1'b1}}, {(N_EXT + 1){1'b0}}};

  logic [DIV_W-1:0]      div_cnt;
  logic                  instr_tick;
  logic [N_EXT-1:0]      ext_evt;
  logic [N_PORT-1:0]     port_lvl;
  logic [N_PORT-1:0]     port_ref;
  logic                  port_mismatch;
  logic [N_SRC-1:0]      src_event;
  logic [N_SRC-1:0]      pend;
  logic                  high_req;
  logic                  low_req;
  tlic_pkg::tlic_state_e state;
  logic [LAT_W-1:0]      lat_cnt;
  logic                  cap_high;
  logic                  accept;
  logic                  ret_hi;
  logic                  ret_lo;

  ////////////////////////////////////////////////////////////////////////////////
  // instruction-cycle enable

  always_ff @(posedge clock) begin
    if (rst) begin
      div_cnt <= '0;
    end else if (div_cnt == DIV_W'(tlic_pkg::INSTR_CLKS - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign instr_tick = (div_cnt == DIV_W'(tlic_pkg::INSTR_CLKS - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  for (genvar i = 0; i < N_EXT; i++) begin : g_ext
    tlic_pin_sync u_sync (
      .clock      (clock),
      .rst        (rst),
      .pin_in     (ext_pin[i]),
      .edge_rise  (ext_pin_edge_select[i]),
      .level      (),
      .edge_event (ext_evt[i])
    );
  end

  for (genvar i = 0; i < N_PORT; i++) begin : g_port
    tlic_pin_sync u_sync (
      .clock      (clock),
      .rst        (rst),
      .pin_in     (port_pin[i]),
      .edge_rise  (1'b1),
      .level      (port_lvl[i]),
      .edge_event ()
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // port-change mismatch

  // a read of the port takes the present levels as the new reference
  always_ff @(posedge clock) begin
    if (rst) begin
      port_ref <= '0;
    end else if (port_read) begin
      port_ref <= port_lvl;
    end
  end

  assign port_mismatch = |(port_lvl ^ port_ref);

  ////////////////////////////////////////////////////////////////////////////////
  // source flags

  always_comb begin
    src_event = {periph_event, port_mismatch, ext_evt};
  end

  // an event in the cycle of its clear still sets the flag
  always_ff @(posedge clock) begin
    if (rst) begin
      src_flag <= {N_SRC{tlic_pkg::FLAG_RESET}};
    end else begin
      src_flag <= (src_flag & ~flag_clear) | src_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // eligibility

  assign pend = src_flag & src_enable;

  always_comb begin
    if (priority_levels_enable) begin
      high_req = high_level_global_enable && |(pend & src_priority);
      low_req  = low_level_global_enable && !high_handler_active
                 && |(pend & ~src_priority);
    end else begin
      // level bits ignored; bit 6 gates only the peripheral group
      high_req = high_level_global_enable
                 && |(pend & (~PERIPH_MASK | {N_SRC{low_level_global_enable}}));
      low_req  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request sequencer

  // the wait is counted in instruction cycles, never in core progress, so
  // latency does not depend on how long the interrupted instruction is
  always_ff @(posedge clock) begin
    if (rst) begin
      state    <= tlic_pkg::TLIC_IDLE;
      lat_cnt  <= '0;
      cap_high <= 1'b0;
    end else begin
      case (state)
        tlic_pkg::TLIC_IDLE: begin
          if (instr_tick && (high_req || low_req)) begin
            state    <= tlic_pkg::TLIC_WAIT;
            lat_cnt  <= LAT_W'(tlic_pkg::LATENCY_INSTR - 1);
            cap_high <= high_req;
          end
        end
        tlic_pkg::TLIC_WAIT: begin
          if (instr_tick) begin
            if (lat_cnt == '0) begin
              state <= tlic_pkg::TLIC_IDLE;
            end else begin
              lat_cnt <= lat_cnt - 1'b1;
            end
          end
        end
        default: begin
          state <= tlic_pkg::TLIC_IDLE;
        end
      endcase
    end
  end

  assign accept = (state == tlic_pkg::TLIC_WAIT) && instr_tick && (lat_cnt == '0);

  ////////////////////////////////////////////////////////////////////////////////
  // core commands

  always_ff @(posedge clock) begin
    if (rst) begin
      stack_push <= 1'b0;
      pc_load    <= 1'b0;
    end else begin
      stack_push <= accept;
      pc_load    <= accept;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pc_vector <= tlic_pkg::HIGH_VECTOR;
    end else if (accept) begin
      pc_vector <= cap_high ? tlic_pkg::HIGH_VECTOR : tlic_pkg::LOW_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // handler tracking

  // with nothing active a return still re-arms bit 7, as compatibility code expects
  assign ret_hi = return_from_handler_instr && (high_handler_active || !low_handler_active);
  assign ret_lo = return_from_handler_instr && !high_handler_active && low_handler_active;

  always_ff @(posedge clock) begin
    if (rst) begin
      high_handler_active <= tlic_pkg::ACTIVE_RESET;
    end else if (accept && cap_high) begin
      high_handler_active <= 1'b1;
    end else if (ret_hi) begin
      high_handler_active <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      low_handler_active <= tlic_pkg::ACTIVE_RESET;
    end else if (accept && !cap_high) begin
      low_handler_active <= 1'b1;
    end else if (ret_lo) begin
      low_handler_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // global enables

  // bit 7: high-level enable, or the all-sources enable in compatibility mode;
  // the hardware clear on acceptance beats a software set in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      high_level_global_enable <= tlic_pkg::GEN_RESET;
    end else if (accept && cap_high) begin
      high_level_global_enable <= 1'b0;
    end else if (ret_hi) begin
      high_level_global_enable <= 1'b1;
    end else if (hi_gen_clr) begin
      high_level_global_enable <= 1'b0;
    end else if (hi_gen_set) begin
      high_level_global_enable <= 1'b1;
    end
  end

  // bit 6: low-level enable, or the peripheral-group enable in compatibility mode
  always_ff @(posedge clock) begin
    if (rst) begin
      low_level_global_enable <= tlic_pkg::GEN_RESET;
    end else if (accept && !cap_high) begin
      low_level_global_enable <= 1'b0;
    end else if (ret_lo) begin
      low_level_global_enable <= 1'b1;
    end else if (lo_gen_clr) begin
      low_level_global_enable <= 1'b0;
    end else if (lo_gen_set) begin
      low_level_global_enable <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: verification/tlic_core_model.sv */
// behavioural processor core: follows vectors and issues returns
`timescale 1ns/10ps
`default_nettype none

module tlic_core_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // controller requests
  input  wire logic        stack_push,
  input  wire logic        pc_load,
  input  wire logic [20:0] pc_vector,
  // bench command for a return
  input  wire logic        ret_req,
  // return instruction and core view
  output var  logic        return_from_handler_instr,
  output var  logic [20:0] pc,
  output var  logic [3:0]  depth
);
  // the core never rewrites control registers itself, so no moves race the enables
  always_ff @(posedge clock) begin
    if (rst) begin
      pc    <= '0;
      depth <= '0;
    end else begin
      if (pc_load) pc <= pc_vector;
      depth <= depth + 4'(stack_push) - 4'(return_from_handler_instr);
    end
  end

  always_ff @(posedge clock) begin
    return_from_handler_instr <= !rst && ret_req;
  end
endmodule
`default_nettype wire

/* File: verification/tlic_props.sv */
// concurrent checks on vector acceptance, enables and flags
`timescale 1ns/10ps
`default_nettype none

module tlic_props #(
  parameter int unsigned N_EXT  = 4,
  parameter int unsigned N_PORT = 4,
  parameter int unsigned N_PER  = 8,
  parameter int unsigned N_SRC  = N_EXT + 1 + N_PER
) (
  // clock and reset
  input wire logic                        clock,
  input wire logic                        rst,
  // software and event inputs
  input wire logic                        priority_levels_enable,
  input wire logic                        return_from_handler_instr,
  input wire logic [N_SRC-1:0]            src_enable,
  input wire logic [N_PER-1:0]            periph_event,
  // core requests and status
  input wire logic                        stack_push,
  input wire logic                        pc_load,
  input wire logic [tlic_pkg::ADDR_W-1:0] pc_vector,
  input wire logic                        high_level_global_enable,
  input wire logic                        low_level_global_enable,
  input wire logic                        high_handler_active,
  input wire logic                        low_handler_active,
  input wire logic [N_SRC-1:0]            src_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  sequence s_accept;
    stack_push && pc_load;
  endsequence
  // capture sits 13 clocks before the accept; up to two clocks earlier is allowed
  sequence s_gated;
    $past(|(src_flag & src_enable), 13) || $past(|(src_flag & src_enable), 14)
      || $past(|(src_flag & src_enable), 15);
  endsequence

  a_push_load_pair: assert property (stack_push == pc_load)
    else $error("push and load apart");
  a_accept_one_pulse: assert property (s_accept |=> !stack_push)
    else $error("accept pulse too long");
  a_vector_known: assert property (s_accept |->
    (pc_vector == tlic_pkg::HIGH_VECTOR || pc_vector == tlic_pkg::LOW_VECTOR))
    else $error("vector not a handler address");
  a_compat_vector: assert property ((pc_load && !priority_levels_enable) |->
    pc_vector == tlic_pkg::HIGH_VECTOR)
    else $error("compat vector wrong");
  a_high_accept_clears: assert property ((pc_load && pc_vector == tlic_pkg::HIGH_VECTOR)
    |-> !high_level_global_enable && high_handler_active)
    else $error("high accept left enable set");
  a_low_accept_clears: assert property ((pc_load && pc_vector == tlic_pkg::LOW_VECTOR)
    |-> !low_level_global_enable && low_handler_active && !high_handler_active)
    else $error("low accept wrong");
  a_enable_gates: assert property (pc_load |-> s_gated)
    else $error("vector without enabled flag");
  a_flag_on_event: assert property (periph_event[0] |=> src_flag[N_EXT+1])
    else $error("event flag not set");
  a_return_high_on: assert property ((return_from_handler_instr && high_handler_active)
    |=> (high_level_global_enable && !high_handler_active) || pc_load)
    else $error("return did not restore");
endmodule

bind tlic_top tlic_props #(.N_EXT(N_EXT), .N_PORT(N_PORT), .N_PER(N_PER), .N_SRC(N_SRC))
  u_tlic_props (.clock(clock), .rst(rst), .priority_levels_enable(priority_levels_enable),
  .return_from_handler_instr(return_from_handler_instr), .src_enable(src_enable),
  .periph_event(periph_event), .stack_push(stack_push), .pc_load(pc_load),
  .pc_vector(pc_vector), .high_level_global_enable(high_level_global_enable),
  .low_level_global_enable(low_level_global_enable), .high_handler_active(high_handler_active),
  .low_handler_active(low_handler_active), .src_flag(src_flag));
`default_nettype wire

/* File: verification/tlic_top_tb.sv */
// self-checking bench of the two-level interrupt controller
`timescale 1ns/10ps
`default_nettype none

module tlic_top_tb;
  typedef struct packed {logic lv, ext, en, pr, hi, lo, got; logic [20:0] vec;} tlic_row_s;
  localparam logic [20:0] H = tlic_pkg::HIGH_VECTOR;
  localparam logic [20:0] L = tlic_pkg::LOW_VECTOR;
  logic clock, rst, priority_levels_enable, hi_gen_set, hi_gen_clr, lo_gen_set, lo_gen_clr;
  logic port_read, ret_req, return_from_handler_instr, stack_push, pc_load, got;
  logic high_level_global_enable, low_level_global_enable, high_handler_active;
  logic low_handler_active;
  logic [12:0] src_enable, src_priority, flag_clear, src_flag, m;
  logic [3:0]  ext_pin_edge_select, ext_pin, port_pin, core_depth;
  logic [7:0]  periph_event;
  logic [20:0] pc_vector, core_pc, v;
  int          fails, checks, n;
  tlic_row_s   rows [0:6];

  always #25 clock = ~clock;

  tlic_top u_tlic_top (.clock(clock), .rst(rst), .priority_levels_enable(priority_levels_enable),
    .hi_gen_set(hi_gen_set), .hi_gen_clr(hi_gen_clr), .lo_gen_set(lo_gen_set),
    .lo_gen_clr(lo_gen_clr), .src_enable(src_enable), .src_priority(src_priority),
    .flag_clear(flag_clear), .ext_pin_edge_select(ext_pin_edge_select), .ext_pin(ext_pin),
    .port_pin(port_pin), .port_read(port_read), .periph_event(periph_event),
    .return_from_handler_instr(return_from_handler_instr), .stack_push(stack_push),
    .pc_load(pc_load), .pc_vector(pc_vector), .high_level_global_enable(high_level_global_enable),
    .low_level_global_enable(low_level_global_enable), .high_handler_active(high_handler_active),
    .low_handler_active(low_handler_active), .src_flag(src_flag));

  tlic_core_model u_tlic_core_model (.clock(clock), .rst(rst), .stack_push(stack_push),
    .pc_load(pc_load), .pc_vector(pc_vector), .ret_req(ret_req),
    .return_from_handler_instr(return_from_handler_instr), .pc(core_pc), .depth(core_depth));

  ////////////////////////////////////////////////////////////
  task close_out;
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task do_reset;
    @(posedge clock);
    rst <= 1'h1; src_enable <= '0; src_priority <= '0; ext_pin <= '0; port_pin <= '0;
    ext_pin_edge_select <= 4'hF; priority_levels_enable <= 1'h0;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
  endtask
  task pulse_gen(input logic h, input logic l);
    @(posedge clock); hi_gen_set <= h; lo_gen_set <= l;
    @(posedge clock); hi_gen_set <= 1'h0; lo_gen_set <= 1'h0;
  endtask
  task fire(input logic [7:0] ev);
    @(posedge clock); periph_event <= ev;
    @(posedge clock); periph_event <= '0;
  endtask
  task clr_flag(input logic [12:0] f);
    @(posedge clock); flag_clear <= f;
    @(posedge clock); flag_clear <= '0;
  endtask
  // an absent vector is judged over a window longer than the worst latency
  task wait_vec(input int lim, input logic must, output logic g, output logic [20:0] vv);
    g = 1'h0; vv = '0;
    for (int i = 0; i < lim && !g; i++) begin
      @(negedge clock);
      if (pc_load === 1'h1) begin g = 1'h1; vv = pc_vector; end
    end
    if (must && !g) begin fails++; close_out(); end
  endtask

  initial begin
    clock = 1'h0; rst = 1'h1; priority_levels_enable = 1'h0; hi_gen_set = 1'h0;
    hi_gen_clr = 1'h0; lo_gen_set = 1'h0; lo_gen_clr = 1'h0; src_enable = '0;
    src_priority = '0; flag_clear = '0; ext_pin_edge_select = 4'hF; ext_pin = '0;
    port_pin = '0; port_read = 1'h0; periph_event = '0; ret_req = 1'h0; fails = 0; checks = 0;
    rows = '{'{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, H},  // high source, high vector
             '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, L},  // low source, low vector
             '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, H},  // own enable clear
             '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, H},  // wrong global enable
             '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, H},  // compat, level bit ignored
             '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, H},  // compat, group disabled
             '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, H}}; // compat pin, not in group
    do_reset();
    @(negedge clock);
    chk("reset outputs", {stack_push, pc_load, high_level_global_enable, low_level_global_enable,
        high_handler_active, low_handler_active, src_flag}, 0);
    chk("reset vector", pc_vector, H);
    for (int i = 0; i < 7; i++) begin
      do_reset();
      m = rows[i].ext ? 13'h1 : 13'h20;
      priority_levels_enable <= rows[i].lv;
      src_enable <= rows[i].en ? m : '0;
      src_priority <= rows[i].pr ? m : '0;
      pulse_gen(rows[i].hi, rows[i].lo);
      if (rows[i].ext) begin @(posedge clock); ext_pin[0] <= 1'h1; end
      else fire(8'h01);
      wait_vec(40, rows[i].got, got, v);
      chk("vector taken", got, rows[i].got);
      if (got) chk("vector address", v, rows[i].vec);
    end
    // both levels at once, then hold-off, return and preemption
    do_reset();
    priority_levels_enable <= 1'h1; src_enable <= 13'h60; src_priority <= 13'h40;
    pulse_gen(1'h1, 1'h1);
    fire(8'h03);
    wait_vec(40, 1'h1, got, v);
    chk("first vector", v, H);
    wait_vec(40, 1'h0, got, v);
    chk("low held off", got, 0);
    clr_flag(13'h40);
    @(posedge clock); ret_req <= 1'h1;
    @(posedge clock); ret_req <= 1'h0;
    wait_vec(40, 1'h1, got, v);
    chk("low after return", v, L);
    chk("high enable back", high_level_global_enable, 1);
    fire(8'h02);
    wait_vec(40, 1'h1, got, v);
    chk("preempt vector", v, H);
    chk("low still active", low_handler_active, 1);
    @(negedge clock);
    chk("core pc", core_pc, H);
    chk("stack depth", core_depth, 2);
    // pin edge choice and latency
    do_reset();
    src_enable <= 13'h1; ext_pin_edge_select <= 4'hE;
    pulse_gen(1'h1, 1'h0);
    @(posedge clock); ext_pin[0] <= 1'h1;
    repeat (8) @(posedge clock);
    chk("rise ignored", src_flag[0], 0);
    ext_pin[0] <= 1'h0;
    for (n = 0; n < 10 && src_flag[0] !== 1'h1; n++) @(negedge clock);
    for (n = 0; n < 30 && pc_load !== 1'h1; n++) @(negedge clock);
    chk("pin latency", (n >= 12 && n <= 20), 1);
    // port mismatch and clear-beats-set
    do_reset();
    @(posedge clock); port_pin[0] <= 1'h1;
    hi_gen_set <= 1'h1; hi_gen_clr <= 1'h1; lo_gen_set <= 1'h1; lo_gen_clr <= 1'h1;
    @(posedge clock); hi_gen_set <= 1'h0; hi_gen_clr <= 1'h0; lo_gen_set <= 1'h0;
    lo_gen_clr <= 1'h0;
    repeat (8) @(posedge clock);
    chk("clr beats set", {high_level_global_enable, low_level_global_enable}, 0);
    chk("port flag", src_flag[4], 1);
    clr_flag(13'h10);
    @(negedge clock);
    chk("flag held", src_flag[4], 1);
    @(posedge clock); port_read <= 1'h1;
    @(posedge clock); port_read <= 1'h0;
    repeat (2) @(posedge clock);
    clr_flag(13'h10);
    @(negedge clock);
    chk("flag cleared", src_flag[4], 0);
    close_out();
  end
endmodule
`default_nettype wire
